// file: core/ppbo_port_core.sv
// port two and port six register and pin logic, with port three drive
`timescale 1ns/100ps
// ----------------------------------------
// ----------------------------------------
module ppbo_port_core (
	input wire logic clock,
	input wire logic rstn,
	input wire logic late_revision,
	input wire logic clock_src,
	input wire ppbo_pkg::ppbo_wr_s port2_wr,
	input wire ppbo_pkg::ppbo_wr_s port6_wr,
	input wire ppbo_pkg::ppbo_byte_t port2_pin_in,
	input wire ppbo_pkg::ppbo_byte_t port6_pin_in,
	input wire ppbo_pkg::ppbo_pin_s port2_periph,
	input wire ppbo_pkg::ppbo_pin_s port6_periph,
	input wire ppbo_pkg::ppbo_byte_t port34_drive_select,
	input wire ppbo_pkg::ppbo_byte_t port3_low_speed_io_out,
	input wire logic bus_mode,
	input wire logic bus_in_phase,
	input wire ppbo_pkg::ppbo_byte_t bus_addr_out,
	output ppbo_pkg::ppbo_rd_s port2_read,
	output ppbo_pkg::ppbo_rd_s port6_read,
	output ppbo_pkg::ppbo_pin_s port2_pins,
	output ppbo_pkg::ppbo_pin_s port6_pins,
	output ppbo_pkg::ppbo_pin_s port3_pins,
	output ppbo_pkg::ppbo_byte_t port2_pull_up,
	output ppbo_pkg::ppbo_byte_t port6_pull_up
);
	import ppbo_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		ppbo_byte_t p2_out; // port two output register
		ppbo_byte_t p2_dir; // port two direction, one = open drain or input
		ppbo_byte_t p2_fsel; // port two function select
		ppbo_byte_t p2_pull; // port two weak pull-up enables
		ppbo_byte_t p6_buf; // port six holding buffer
		ppbo_byte_t p6_out; // port six output register
		ppbo_byte_t p6_dir; // port six direction
		ppbo_byte_t p6_fsel; // port six function select
		ppbo_byte_t p6_pull; // port six weak pull-up enables
		ppbo_pin_s p2_drv; // registered port two drive
		ppbo_pin_s p6_drv; // registered port six drive
		ppbo_rd_s p2_rd; // registered port two read-back
		ppbo_rd_s p6_rd; // registered port six read-back
	} ppbo_state_s;

	localparam ppbo_rd_s RD_RST = '{out: NO_BITS, dir: NO_BITS, fsel: NO_BITS,
		pin: NO_BITS}; // read-back before the first sample

	// reset clears port six buffer and register
	localparam ppbo_state_s ST_RST = '{
		p2_out: P2_OUT_RST, p2_dir: P2_DIR_RST, p2_fsel: P2_FSEL_RST,
		p2_pull: PULL_RST, p6_buf: P6_BUF_RST, p6_out: P6_OUT_RST,
		p6_dir: P6_DIR_RST, p6_fsel: P6_FSEL_RST, p6_pull: PULL_RST,
		p2_drv: '{out: DRV_OUT_RST, oe: P2_OE_RST},
		p6_drv: '{out: DRV_OUT_RST, oe: P6_OE_RST},
		p2_rd: RD_RST, p6_rd: RD_RST};

	ppbo_state_s st; // present state
	ppbo_state_s next_st; // next state
	ppbo_byte_t wmask2; // bits of port two that writes may change
	ppbo_byte_t wmask6; // bits of port six that writes may change

	// ----------------------------------------
	// helper functions
	// ----------------------------------------
	// bits that exist as storage; the late revision has no removed-pin logic
	function automatic ppbo_byte_t live_mask(input logic late, input ppbo_byte_t removed);
		live_mask = late ? ~removed : ALL_BITS;
	endfunction

	// masked write: bits outside the mask keep their old value
	function automatic ppbo_byte_t merge(input ppbo_byte_t old, input ppbo_byte_t data,
		input ppbo_byte_t mask);
		merge = (old & ~mask) | (data & mask);
	endfunction

	// read value with removed bits forced on the late revision
	function automatic ppbo_byte_t fix_read(input ppbo_byte_t val, input logic late,
		input ppbo_byte_t removed, input ppbo_byte_t fixed);
		fix_read = late ? ((val & ~removed) | (fixed & removed)) : val;
	endfunction

	// drive of one port from its registers and peripheral
	function automatic ppbo_pin_s pin_drive(input ppbo_byte_t out, input ppbo_byte_t dir,
		input ppbo_byte_t fsel, input ppbo_byte_t pull, input ppbo_pin_s periph,
		input ppbo_byte_t pp_only, input ppbo_byte_t gone);
		ppbo_pin_s d;
		ppbo_byte_t low_speed_io_oe;
		d = '{out: NO_BITS, oe: NO_BITS};
		// open drain drives only a low; push-pull-only bits ignore dir
		low_speed_io_oe = (~dir | ~out | pp_only) & (~pull | pp_only);
		d.out = (fsel & periph.out) | (~fsel & out);
		d.oe = (fsel & (periph.oe | pp_only)) | (~fsel & low_speed_io_oe);
		// absent pins have no driver at all
		d.oe = d.oe & ~gone;
		pin_drive = d;
	endfunction

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	assign wmask2 = live_mask(late_revision, P2_REMOVED);
	assign wmask6 = live_mask(late_revision, P6_REMOVED);

	always_comb begin
		next_st = st;
		// early revision keeps removed bits writable
		if (port2_wr.out_wr) begin
			next_st.p2_out = merge(st.p2_out, port2_wr.data, wmask2);
		end
		if (port2_wr.dir_wr) begin
			next_st.p2_dir = merge(st.p2_dir, port2_wr.data, wmask2);
		end
		if (port2_wr.fsel_wr) begin
			next_st.p2_fsel = merge(st.p2_fsel, port2_wr.data, wmask2);
			next_st.p2_pull = st.p2_pull & ~wmask2;
		end
		next_st.p6_out = (st.p6_out & st.p6_fsel) | (st.p6_buf & ~st.p6_fsel);
		// output writes go to the buffer only; direction and function-select writes go straight to their registers
		if (port6_wr.out_wr) begin
			next_st.p6_buf = merge(st.p6_buf, port6_wr.data, wmask6);
		end
		if (port6_wr.dir_wr) begin
			next_st.p6_dir = merge(st.p6_dir, port6_wr.data, wmask6);
		end
		if (port6_wr.fsel_wr) begin
			next_st.p6_fsel = merge(st.p6_fsel, port6_wr.data, wmask6);
			next_st.p6_pull = st.p6_pull & ~wmask6;
		end
		next_st.p2_drv = pin_drive(st.p2_out, st.p2_dir, st.p2_fsel, st.p2_pull,
			port2_periph, CLK_MASK, late_revision ? P2_REMOVED : NO_BITS);
		next_st.p6_drv = pin_drive(st.p6_out, st.p6_dir, st.p6_fsel, st.p6_pull,
			port6_periph, NO_BITS, late_revision ? P6_REMOVED : NO_BITS);
		next_st.p2_rd.out = fix_read(st.p2_out, late_revision, P2_REMOVED, FIXED_ONES);
		next_st.p2_rd.dir = fix_read(st.p2_dir, late_revision, P2_REMOVED, FIXED_ONES);
		next_st.p2_rd.fsel = fix_read(st.p2_fsel, late_revision, P2_REMOVED, FIXED_ZEROS);
		next_st.p2_rd.pin = fix_read(port2_pin_in, late_revision, P2_REMOVED, FIXED_ONES);
		next_st.p6_rd.out = fix_read(st.p6_out, late_revision, P6_REMOVED, FIXED_ONES);
		next_st.p6_rd.dir = fix_read(st.p6_dir, late_revision, P6_REMOVED, FIXED_ONES);
		next_st.p6_rd.fsel = fix_read(st.p6_fsel, late_revision, P6_REMOVED, FIXED_ZEROS);
		next_st.p6_rd.pin = fix_read(port6_pin_in, late_revision, P6_REMOVED, FIXED_ONES);
	end

	// one register for the whole state
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st <= ST_RST;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign port2_read = st.p2_rd;
	assign port6_read = st.p6_rd;
	assign port6_pins = st.p6_drv;
	assign port2_pull_up = st.p2_pull;
	assign port6_pull_up = st.p6_pull;

	// clock passes straight to its pin; a register would halve it
	always_comb begin
		port2_pins = st.p2_drv;
		if (st.p2_fsel[CLK_BIT]) begin
			port2_pins.out[CLK_BIT] = clock_src;
		end
	end

	// port three drive lives in its own block
	ppbo_port3_drive u_port3 (
		.clock(clock),
		.rstn(rstn),
		.port34_drive_select(port34_drive_select),
		.low_speed_io_out(port3_low_speed_io_out),
		.bus_mode(bus_mode),
		.bus_in_phase(bus_in_phase),
		.bus_addr_out(bus_addr_out),
		.port3_pins(port3_pins)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	buf_capture_a: assert property (
		@(posedge clock) disable iff (!rstn)
		(port6_wr.out_wr && !late_revision) |=> st.p6_buf == $past(port6_wr.data))
		else $error("port six write did not reach the buffer");

	buf_transfer_a: assert property (
		@(posedge clock) disable iff (!rstn)
		1'b1 |=> ((st.p6_out ^ $past(st.p6_buf)) & ~$past(st.p6_fsel)) == NO_BITS)
		else $error("buffer not moved into a deselected bit");

	buf_hold_a: assert property (
		@(posedge clock) disable iff (!rstn)
		1'b1 |=> ((st.p6_out ^ $past(st.p6_out)) & $past(st.p6_fsel)) == NO_BITS)
		else $error("selected port six bit changed its register");

	read_register_a: assert property (
		@(posedge clock) disable iff (!rstn)
		!late_revision |=> port6_read.out == $past(st.p6_out))
		else $error("port six read does not show the register");

	clock_pushpull_a: assert property (
		@(posedge clock) disable iff (!rstn)
		(st.p2_dir[CLK_BIT] && !st.p2_pull[CLK_BIT]) |=> port2_pins.oe[CLK_BIT])
		else $error("clock pin released by open-drain setting");

	clock_in_reset_a: assert property (
		@(posedge clock)
		!rstn |-> (port2_pins.oe[CLK_BIT] && port2_pins.out[CLK_BIT] == clock_src))
		else $error("clock output missing during reset");

	pull_hold_a: assert property (
		@(posedge clock) disable iff (!rstn)
		(st.p2_pull[0] && !port2_wr.fsel_wr) |=> st.p2_pull[0])
		else $error("pull-up dropped without a function-select write");

	removed_rw_a: assert property (
		@(posedge clock) disable iff (!rstn)
		(!late_revision && port2_wr.dir_wr) ##1 !late_revision
		|=> port2_read.dir == $past(port2_wr.data, 2))
		else $error("removed bit did not read back its write");

	removed_fixed_a: assert property (
		@(posedge clock) disable iff (!rstn)
		// read-back is only valid from the second edge after release
		($past(rstn) && $past(late_revision)) |-> ((port6_read.fsel & P6_REMOVED) == NO_BITS
		&& (port6_read.dir & P6_REMOVED) == P6_REMOVED))
		else $error("removed port six bits not fixed");

endmodule

// file: include/ppbo_pkg.sv
// constants and carrier types for the port pin logic
package ppbo_pkg;

	// ----------------------------------------
	// basic types
	// ----------------------------------------
	typedef logic [7:0] ppbo_byte_t; // one port's worth of bits

	// software write strobes for one port, each a one-cycle pulse
	typedef struct packed {
		logic out_wr; // write to the output register
		logic dir_wr; // write to the direction register
		logic fsel_wr; // write to the function-select register
		ppbo_byte_t data; // write data for any of the strobes
	} ppbo_wr_s;

	// read-back values of one port, registered
	typedef struct packed {
		ppbo_byte_t out; // output register contents
		ppbo_byte_t dir; // direction register contents
		ppbo_byte_t fsel; // function-select contents
		ppbo_byte_t pin; // pin state
	} ppbo_rd_s;

	// pin drive for one port: level plus output enable (high = driving)
	typedef struct packed {
		ppbo_byte_t out; // level driven
		ppbo_byte_t oe; // output enable, high while driven
	} ppbo_pin_s;

	// ----------------------------------------
	// pins missing on the reduced-pin device
	// ----------------------------------------
	localparam ppbo_byte_t P2_REMOVED = 8'h28; // port two bits 3 and 5
	localparam ppbo_byte_t P6_REMOVED = 8'h0C; // port six bits 2 and 3
	localparam ppbo_byte_t FIXED_ONES = 8'hFF; // late revision: pin, out, dir read one
	localparam ppbo_byte_t FIXED_ZEROS = 8'h00; // late revision: fsel reads zero
	localparam ppbo_byte_t ALL_BITS = 8'hFF; // write mask that touches every bit
	localparam ppbo_byte_t NO_BITS = 8'h00; // empty mask

	// ----------------------------------------
	// clock output pin
	// ----------------------------------------
	localparam int CLK_BIT = 7; // port two bit carrying the clock output
	localparam ppbo_byte_t CLK_MASK = 8'h80; // same bit as a mask

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam ppbo_byte_t P2_OUT_RST = 8'hFF; // port two output register
	localparam ppbo_byte_t P2_DIR_RST = 8'hFF; // port two direction register
	localparam ppbo_byte_t P2_FSEL_RST = 8'h80; // clock output selected from reset
	localparam ppbo_byte_t P2_OE_RST = 8'h80; // port two drives only its clock pin in reset
	localparam ppbo_byte_t P6_OUT_RST = 8'h00; // port six output register
	localparam ppbo_byte_t P6_BUF_RST = 8'h00; // port six holding buffer
	localparam ppbo_byte_t P6_DIR_RST = 8'hFF; // port six direction register
	localparam ppbo_byte_t P6_FSEL_RST = 8'h00; // port six function select
	localparam ppbo_byte_t P6_OE_RST = 8'h00; // port six drives nothing in reset
	localparam ppbo_byte_t PULL_RST = 8'hFF; // weak pull-ups on in reset
	localparam ppbo_byte_t DRV_OUT_RST = 8'h00; // registered drive level in reset
	localparam ppbo_byte_t P3_OUT_RST = 8'h00; // port three drive level in reset

endpackage

// file: core/ppbo_port3_drive.sv
// port three pin drive shared with the external address/data bus
`timescale 1ns/100ps
module ppbo_port3_drive (
	input wire logic clock,
	input wire logic rstn,
	input wire ppbo_pkg::ppbo_byte_t port34_drive_select,
	input wire ppbo_pkg::ppbo_byte_t low_speed_io_out,
	input wire logic bus_mode,
	input wire logic bus_in_phase,
	input wire ppbo_pkg::ppbo_byte_t bus_addr_out,
	output ppbo_pkg::ppbo_pin_s port3_pins
);
	import ppbo_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		ppbo_byte_t out; // registered drive level
	} ppbo_p3_state_s;

	ppbo_p3_state_s st; // present state
	ppbo_p3_state_s next_st; // next state
	ppbo_byte_t low_speed_io_oe; // enable for low-speed use

	// drive level follows bus address or low-speed data
	always_comb begin
		next_st = st;
		if (bus_mode) begin
			next_st.out = bus_addr_out;
		end else begin
			next_st.out = low_speed_io_out;
		end
	end

	// one register for the whole state
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st <= '{out: P3_OUT_RST};
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// output enable
	// ----------------------------------------
	// push-pull bits drive both levels, the rest only pull low
	assign low_speed_io_oe = port34_drive_select | ~st.out;

	// enable is kept combinational so the release is never a cycle late
	always_comb begin
		if (bus_in_phase) begin
			port3_pins.oe = NO_BITS;
		end else if (bus_mode) begin
			port3_pins.oe = ALL_BITS;
		end else begin
			port3_pins.oe = low_speed_io_oe;
		end
		port3_pins.out = st.out;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	bus_release_a: assert property (
		@(posedge clock) disable iff (!rstn)
		bus_in_phase |-> port3_pins.oe == NO_BITS)
		else $error("port three drives while the bus is reading");

endmodule

// file: tb/ppbo_pin_board.sv
// board-side model of one port's pins: drivers, weak pull-ups, floating lines
`timescale 1ns/100ps
module ppbo_pin_board (
	input wire logic clock,
	input wire ppbo_pkg::ppbo_pin_s pins,
	input wire ppbo_pkg::ppbo_byte_t pull_up,
	input wire ppbo_pkg::ppbo_byte_t ext_drive,
	input wire ppbo_pkg::ppbo_byte_t ext_level,
	output ppbo_pkg::ppbo_byte_t pin_level
);
	import ppbo_pkg::*;
	// ----------------------------------------
	// line state
	// ----------------------------------------
	ppbo_byte_t last = 8'h00; // level seen on the previous cycle
	// remember each line so a floating one can be made to wander
	always_ff @(posedge clock) begin
		last <= pin_level;
	end
	// ----------------------------------------
	// wire resolution
	// ----------------------------------------
	// device driver wins, then board driver, then pull-up; a bare line flips every
	// cycle so the design can never rely on a lucky settled value
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pins.oe[i]) begin
				pin_level[i] = pins.out[i]; // device drives
			end else if (ext_drive[i]) begin
				pin_level[i] = ext_level[i]; // board drives
			end else if (pull_up[i]) begin
				pin_level[i] = 1'b1; // weak pull-up
			end else begin
				pin_level[i] = ~last[i]; // floating
			end
		end
	end
endmodule

// file: tb/port_pin_buffered_output_tb.sv
// self-checking bench for the port pin core with board models on ports two and six
`timescale 1ns/100ps
module port_pin_buffered_output_tb;
	import ppbo_pkg::*;
	// ----------------------------------------
	// stimulus and observation
	// ----------------------------------------
	logic clock, rstn, late_revision, clock_src, bus_mode, bus_in_phase;
	ppbo_wr_s port2_wr, port6_wr; // write strobes
	ppbo_byte_t port2_pin_in, port6_pin_in, port34_drive_select, port3_low_speed_io_out, bus_addr_out;
	ppbo_pin_s port2_periph, port6_periph, port2_pins, port6_pins, port3_pins;
	ppbo_rd_s port2_read, port6_read; // read-back
	ppbo_byte_t port2_pull_up, port6_pull_up, ext_drive, ext_level;
	int num_errors = 0;
	int num_checks = 0;
	int cycles = 0; // hang guard
	localparam int OUT = 0; // write kinds
	localparam int DIR = 1;
	localparam int FSEL = 2;
	ppbo_port_core uut (.clock(clock), .rstn(rstn), .late_revision(late_revision),
		.clock_src(clock_src), .port2_wr(port2_wr), .port6_wr(port6_wr),
		.port2_pin_in(port2_pin_in), .port6_pin_in(port6_pin_in),
		.port2_periph(port2_periph), .port6_periph(port6_periph),
		.port34_drive_select(port34_drive_select), .port3_low_speed_io_out(port3_low_speed_io_out),
		.bus_mode(bus_mode), .bus_in_phase(bus_in_phase), .bus_addr_out(bus_addr_out),
		.port2_read(port2_read), .port6_read(port6_read), .port2_pins(port2_pins),
		.port6_pins(port6_pins), .port3_pins(port3_pins),
		.port2_pull_up(port2_pull_up), .port6_pull_up(port6_pull_up));
	ppbo_pin_board board2 (.clock(clock), .pins(port2_pins), .pull_up(port2_pull_up),
		.ext_drive(ext_drive), .ext_level(ext_level), .pin_level(port2_pin_in));
	ppbo_pin_board board6 (.clock(clock), .pins(port6_pins), .pull_up(port6_pull_up),
		.ext_drive(ext_drive), .ext_level(ext_level), .pin_level(port6_pin_in));
	// ----------------------------------------
	// clock and hang guard
	// ----------------------------------------
	always #5 clock = ~clock;
	// the whole run is well under a thousand cycles, so 5000 means a hang
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			wrap_up();
		end
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	// verdict and end of run
	task automatic wrap_up();
		if (num_errors == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// compare seen against expected
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one-cycle write strobe, then time for buffer, register and read-back to settle
	task automatic wr(input logic p6, input int k, input ppbo_byte_t d);
		ppbo_wr_s w;
		w = '0;
		w.data = d;
		w.out_wr = (k == OUT);
		w.dir_wr = (k == DIR);
		w.fsel_wr = (k == FSEL);
		if (p6) port6_wr = w;
		else port2_wr = w;
		@(posedge clock);
		#1;
		port2_wr = '0;
		port6_wr = '0;
		repeat (4) @(posedge clock);
		#1;
	endtask
	// reset held four cycles, revision chosen while held
	task automatic do_reset(input logic late);
		rstn = 1'b0;
		late_revision = late;
		repeat (4) @(posedge clock);
		#1;
		rstn = 1'b1;
		repeat (2) @(posedge clock);
		#1;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		rstn = 1'b1; // dropped a step in, so the reset flops see the edge
		late_revision = 1'b0;
		clock_src = 1'b1;
		port2_wr = '0;
		port6_wr = '0;
		port2_periph = '0;
		port6_periph = '{out: 8'h00, oe: 8'h10}; // peripheral drives low on bit 4
		port34_drive_select = 8'h00;
		port3_low_speed_io_out = 8'h00;
		bus_mode = 1'b0;
		bus_in_phase = 1'b0;
		bus_addr_out = 8'h5A;
		ext_drive = 8'h00; // board leaves every line to the device
		ext_level = 8'h00;
		#1;
		rstn = 1'b0;
		repeat (2) @(posedge clock);
		#1;
		// clock on its pin in reset
		chk({7'h00, port2_pins.out[CLK_BIT]}, 8'h01);
		chk(port2_pins.oe, 8'h80);
		clock_src = 1'b0;
		#1;
		chk({7'h00, port2_pins.out[CLK_BIT]}, 8'h00);
		chk(port2_pull_up, 8'hFF);
		// rest of the four reset cycles, then release
		repeat (2) @(posedge clock);
		#1;
		rstn = 1'b1;
		repeat (2) @(posedge clock);
		#1;
		chk(port6_read.out, 8'h00);
		// pull-ups survive other writes and hold drivers off
		wr(1'b1, DIR, 8'h00);
		chk(port6_pull_up, 8'hFF);
		chk(port6_pins.oe, 8'h00);
		wr(1'b1, FSEL, 8'h10);
		chk(port6_pull_up, 8'h00);
		// held write, only deselected bits move
		wr(1'b1, OUT, 8'hF0);
		chk(port6_read.out, 8'hE0);
		chk(port6_pins.out, 8'hE0);
		chk(port6_pins.oe, 8'hFF);
		chk(port6_read.pin, 8'hE0);
		// clearing select releases the held bit
		wr(1'b1, FSEL, 8'h00);
		chk(port6_read.out, 8'hF0);
		chk(port6_pins.out, 8'hF0);
		wr(1'b1, DIR, 8'h0C);
		chk(port6_read.dir, 8'h0C);
		wr(1'b1, DIR, 8'h00);
		wr(1'b0, DIR, 8'h28);
		chk(port2_read.dir, 8'h28);
		wr(1'b0, DIR, 8'hD7);
		// clock pin keeps driving though set open drain
		wr(1'b0, FSEL, 8'h00);
		chk(port2_read.fsel, 8'h00);
		chk(port2_pins.oe, 8'hA8);
		chk({7'h00, port2_pins.out[CLK_BIT]}, 8'h01);
		// port three push-pull and bus turnaround
		port34_drive_select = 8'hFF;
		port3_low_speed_io_out = 8'h0F;
		repeat (2) @(posedge clock);
		#1;
		chk(port3_pins.oe, 8'hFF);
		chk(port3_pins.out, 8'h0F);
		bus_mode = 1'b1;
		bus_in_phase = 1'b1;
		#1;
		chk(port3_pins.oe, 8'h00);
		@(posedge clock);
		#1;
		bus_in_phase = 1'b0;
		#1;
		chk(port3_pins.oe, 8'hFF);
		@(posedge clock);
		#1;
		chk(port3_pins.out, 8'h5A);
		bus_mode = 1'b0;
		do_reset(1'b1);
		wr(1'b1, DIR, 8'h00);
		chk(port6_read.dir, 8'h0C);
		wr(1'b1, FSEL, 8'hFF);
		chk(port6_read.fsel, 8'hF3);
		chk(port6_read.pin & P6_REMOVED, 8'h0C);
		chk(port6_pins.oe & P6_REMOVED, 8'h00);
		wr(1'b0, OUT, 8'h00);
		chk(port2_read.out, 8'h28);
		wrap_up();
	end
endmodule
